// >>> fiwt_assertions.sv
// Checker for the timer events
`timescale 1ns/10ps
`default_nettype none
module fiwt_chk
(
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic [1:0]  fix_sel,
   input wire logic [1:0]  wdg_sel,
   input wire logic [1:0]  wdg_rst_type,
   input wire logic [63:0] time_base,
   input wire logic        fixed_interval_event,
   input wire logic        wdg_rst_req,
   input wire logic [1:0]  wdg_rst_req_type
);
   wire fb = time_base[9+4*fix_sel];
   wire wb = time_base[11+2*wdg_sel];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence fix_up; $rose(fb) && $stable(fix_sel); endsequence
   sequence wdg_up; $rose(wb) && $stable(wdg_sel); endsequence
   fix_rise_a: assert property (fix_up |-> fixed_interval_event) else $error("fix miss");
   fix_edge_a: assert property (fixed_interval_event && $stable(fix_sel) |-> fb && !$past(fb))
      else $error("fix stray");
   fix_once_a: assert property (fixed_interval_event |=> !fixed_interval_event)
      else $error("fix long");
   wdg_rise_a: assert property (wdg_up |-> wdg_rst_req) else $error("wdg miss");
   wdg_once_a: assert property (wdg_rst_req |=> !wdg_rst_req) else $error("wdg long");
   wdg_type_a: assert property (wdg_rst_req |-> wdg_rst_req_type == $past(wdg_rst_type))
      else $error("bad type");
   type_hold_a: assert property (!wdg_rst_req |-> $stable(wdg_rst_req_type))
      else $error("type moved");
   tb_step_a: assert property ($changed(time_base) |-> time_base == $past(time_base) + 1)
      else $error("bad step");
endmodule
bind fiwt_timer fiwt_chk chk (.clk_sys, .rst_b, .fix_sel, .wdg_sel, .wdg_rst_type,
   .time_base, .fixed_interval_event, .wdg_rst_req, .wdg_rst_req_type);
`default_nettype wire

// >>> fiwt_core.sv
// Core side model counting timer events
`timescale 1ns/10ps
`default_nettype none
module fiwt_core
(
   input wire logic       clk_sys,
   input wire logic       fixed_interval_event,
   input wire logic       wdg_rst_req,
   output var logic [7:0] n_ev
);
   initial n_ev = 8'h00;
   always @(posedge clk_sys)
      n_ev <= n_ev + 8'(fixed_interval_event) + 8'(wdg_rst_req);
endmodule
`default_nettype wire

// >>> fiwt_defines.vh
// Constants for the fixed-interval and watchdog timer block
`ifndef FIWT_DEFINES_VH
`define FIWT_DEFINES_VH

// ****************************************
// Time base
// ****************************************
`define FIWT_TB_W        64
`define FIWT_TB_ONE      64'h0000_0000_0000_0001
`define FIWT_TB_ZERO     64'h0000_0000_0000_0000

// ****************************************
// Selectable trigger bits (bit index in time base)
// ****************************************
`define FIWT_FIX_BIT0    9
`define FIWT_FIX_BIT1    13
`define FIWT_FIX_BIT2    17
`define FIWT_FIX_BIT3    21
// Watchdog taps kept low so a full expiry stays within a short run
`define FIWT_WDG_BIT0    11
`define FIWT_WDG_BIT1    13
`define FIWT_WDG_BIT2    15
`define FIWT_WDG_BIT3    17

// ****************************************
// Selection codes and reset types
// ****************************************
`define FIWT_SEL_W       2
`define FIWT_SEL_0       2'h0
`define FIWT_SEL_1       2'h1
`define FIWT_SEL_2       2'h2
`define FIWT_SEL_3       2'h3
`define FIWT_RST_W       2
`define FIWT_RST_NONE    2'h0

`endif

// >>> fiwt_timer.v
// Time base with fixed-interval and watchdog edge events
`timescale 1ns/10ps
`default_nettype none
`include "fiwt_defines.vh"

module fiwt_timer
(
   input  wire                     clk_sys,
   input  wire                     rst_b,
   input  wire                     ext_tick,
   input  wire                     use_ext_tick,
   input  wire [`FIWT_SEL_W-1:0]   fix_sel,
   input  wire [`FIWT_SEL_W-1:0]   wdg_sel,
   input  wire [`FIWT_RST_W-1:0]   wdg_rst_type,
   output reg  [`FIWT_TB_W-1:0]    time_base,
   output reg                      fixed_interval_event,
   output reg                      wdg_rst_req,
   output reg  [`FIWT_RST_W-1:0]   wdg_rst_req_type
);

   // ****************************************
   // Bit pick functions
   // ****************************************
   function pick_fix;
      input [`FIWT_TB_W-1:0]  tb;
      input [`FIWT_SEL_W-1:0] sel;
      begin
         case (sel)
            `FIWT_SEL_0: pick_fix = tb[`FIWT_FIX_BIT0];
            `FIWT_SEL_1: pick_fix = tb[`FIWT_FIX_BIT1];
            `FIWT_SEL_2: pick_fix = tb[`FIWT_FIX_BIT2];
            default:     pick_fix = tb[`FIWT_FIX_BIT3];
         endcase
      end
   endfunction

   function pick_wdg;
      input [`FIWT_TB_W-1:0]  tb;
      input [`FIWT_SEL_W-1:0] sel;
      begin
         case (sel)
            `FIWT_SEL_0: pick_wdg = tb[`FIWT_WDG_BIT0];
            `FIWT_SEL_1: pick_wdg = tb[`FIWT_WDG_BIT1];
            `FIWT_SEL_2: pick_wdg = tb[`FIWT_WDG_BIT2];
            default:     pick_wdg = tb[`FIWT_WDG_BIT3];
         endcase
      end
   endfunction

   // ****************************************
   // External tick synchroniser
   // ****************************************
   // Pin is asynchronous; edge detect reads the second stage and its delayed copy tick_last
   reg  tick_meta;
   reg  tick_sync;
   reg  tick_last;
   reg  sel_sync_meta;
   reg  sel_sync;
   wire tb_step;

   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tick_meta     <= 1'b0;
         tick_sync     <= 1'b0;
         tick_last     <= 1'b0;
         sel_sync_meta <= 1'b0;
         sel_sync      <= 1'b0;
      end
      else
      begin
         tick_meta     <= ext_tick;
         tick_sync     <= tick_meta;
         tick_last     <= tick_sync;
         sel_sync_meta <= use_ext_tick;
         sel_sync      <= sel_sync_meta;
      end
   end

   // External source steps once per rising tick, else every clock
   assign tb_step = sel_sync ? (tick_sync & ~tick_last) : 1'b1;

   // ****************************************
   // Time base and edge detection
   // ****************************************
   reg  fix_prev;
   reg  wdg_prev;
   wire [`FIWT_TB_W-1:0] next_time_base;
   wire fix_now;
   wire wdg_now;

   assign next_time_base = time_base + `FIWT_TB_ONE;
   // Selected bit sampled from the freshly advanced value
   assign fix_now = pick_fix(next_time_base, fix_sel);
   assign wdg_now = pick_wdg(next_time_base, wdg_sel);

   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         time_base            <= `FIWT_TB_ZERO;
         fix_prev             <= 1'b0;
         wdg_prev             <= 1'b0;
         fixed_interval_event <= 1'b0;
         wdg_rst_req          <= 1'b0;
         wdg_rst_req_type     <= `FIWT_RST_NONE;
      end
      else
      begin
         fixed_interval_event <= 1'b0;
         wdg_rst_req          <= 1'b0;
         if (tb_step)
         begin
            time_base <= next_time_base;
            fix_prev  <= fix_now;
            wdg_prev  <= wdg_now;
            // Selection change may fake one edge; accepted as the simplest choice
            fixed_interval_event <= fix_now & ~fix_prev;
            if (wdg_now & ~wdg_prev)
            begin
               wdg_rst_req      <= 1'b1;
               wdg_rst_req_type <= wdg_rst_type;
            end
         end
      end
   end

endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin checks_done++; if ((a)!==(b)) begin err_count++; $display("[ERR] %0t %h %h",$time,a,b); end end
module tb_top;
   logic        clk_sys, rst_b, ext_tick, use_ext_tick, fi_ev, wr_req;
   logic [1:0]  fix_sel, wdg_sel, wdg_rst_type, wr_type;
   logic [63:0] time_base, t0;
   logic [7:0]  n_ev;
   int          err_count, checks_done, n;
   fiwt_timer uut (.clk_sys, .rst_b, .ext_tick, .use_ext_tick, .fix_sel, .wdg_sel,
      .wdg_rst_type, .time_base, .fixed_interval_event(fi_ev), .wdg_rst_req(wr_req),
      .wdg_rst_req_type(wr_type));
   fiwt_core core (.clk_sys, .fixed_interval_event(fi_ev), .wdg_rst_req(wr_req), .n_ev);
   task close_out;
      if (err_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task wait_ev(input logic [63:0] exp);
      for (n = 0; !(fi_ev | wr_req) && n < 40000; n++)
         @(negedge clk_sys);
      `CHK(n < 40000, 1'b1)
      if (n >= 40000)
         close_out;
      `CHK(time_base, exp)
      @(negedge clk_sys);
   endtask
   task t_fix;
      wait_ev(64'h200);
      fix_sel = 2'h1;
      wait_ev(64'h2000);
   endtask
   task t_ext;
      use_ext_tick = 1;
      repeat (4) @(negedge clk_sys);
      t0 = time_base;
      repeat (6)
      begin
         ext_tick = ~ext_tick;
         repeat (4) @(negedge clk_sys);
      end
      `CHK(time_base, t0 + 64'h3)
      use_ext_tick = 0;
   endtask
   task t_wdg;
      wdg_rst_type = 2'h2;
      fix_sel = 2'h3;
      wdg_sel = 2'h2;
      wait_ev(64'h8000);
      `CHK(wr_type, 2'h2)
      `CHK(n_ev, 8'h03)
   endtask
   task t_rst;
      rst_b = 0;
      #1;
      `CHK({time_base, wr_type}, 66'h0)
      repeat (2) @(negedge clk_sys);
      rst_b = 1;
      @(negedge clk_sys);
      `CHK(time_base, 64'h1)
   endtask
   initial
      forever
         #5 clk_sys = ~clk_sys;
   initial
   begin
      {clk_sys, rst_b, ext_tick, use_ext_tick, fix_sel, wdg_sel, wdg_rst_type} = '0;
      wdg_sel = 2'h3;
      repeat (10) @(negedge clk_sys);
      rst_b = 1;
      t_fix;
      t_ext;
      t_wdg;
      t_rst;
      close_out;
   end
endmodule
`default_nettype wire
